// ---- rtl/esd_pkg.sv ----
`default_nettype none
package esd_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] CONV_A_SEQ_ADDR    = 8'h0C;
   localparam logic [7:0] CONV_B_SEQ_ADDR    = 8'h0D;
   localparam logic [7:0] LIN_REG_A_SEQ_ADDR = 8'h0E;
   localparam logic [7:0] LIN_REG_B_SEQ_ADDR = 8'h0F;
   localparam logic [7:0] GP_OUTPUT_SEQ_ADDR = 8'h10;
   localparam logic [7:0] CONFIG_ADDR        = 8'h13;

   localparam logic [7:0] SEQ_RESET    = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;

   // ==========================================================
   // Field layout
   localparam int UP_LSB            = 0;
   localparam int DOWN_LSB          = 4;
   localparam int CODE_W            = 4;
   localparam int UP_RANGE_BIT      = 6;
   localparam int DOWN_RANGE_BIT    = 5;
   localparam logic [7:0] CONFIG_MASK = 8'h60;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS  = 40;
   localparam int HALF_STEP_NS   = 500000;
   localparam int HALF_STEP_CYCLES = (HALF_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HALF_STEPS_W   = 5;
   localparam int NUM_OUTPUTS    = 5;

   // ==========================================================
   // Register access from the serial interface
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } esd_reg_req_s;

endpackage : esd_pkg
`default_nettype wire

// ---- rtl/esd_seq_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module esd_seq_timer
   import esd_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              rise_i,
   input  wire logic              fall_i,
   input  wire logic              tick_i,
   input  wire logic [CODE_W-1:0] up_code_i,
   input  wire logic [CODE_W-1:0] down_code_i,
   input  wire logic              up_long_i,
   input  wire logic              down_long_i,
   output logic                   out_o
);

   logic [HALF_STEPS_W-1:0] remaining;
   logic                    pending;
   logic                    target;

   // Code and range are captured at the edge; later writes affect the next edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_o     <= 1'b0;
         remaining <= '0;
         pending   <= 1'b0;
         target    <= 1'b0;
      end else if (rise_i) begin
         target <= 1'b1;
         if (up_code_i == '0) begin
            out_o   <= 1'b1;
            pending <= 1'b0;
         end else begin
            remaining <= up_long_i ? {up_code_i, 1'b0} : {1'b0, up_code_i};
            pending   <= 1'b1;
         end
      end else if (fall_i) begin
         target <= 1'b0;
         if (down_code_i == '0) begin
            out_o   <= 1'b0;
            pending <= 1'b0;
         end else begin
            remaining <= down_long_i ? {down_code_i, 1'b0} : {1'b0, down_code_i};
            pending   <= 1'b1;
         end
      end else if (pending && tick_i) begin
         remaining <= remaining - 1'b1;
         if (remaining == HALF_STEPS_W'(1)) begin
            out_o   <= target;
            pending <= 1'b0;
         end
      end
   end

endmodule : esd_seq_timer
`default_nettype wire

// ---- rtl/esd_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module esd_sequencer
   import esd_pkg::*;
#(
   parameter int HALF_STEP_CNT = HALF_STEP_CYCLES
)(
   input  wire logic                  CLK_I,
   input  wire logic                  SYS_RST_I,
   input  wire logic                  EN_PIN_I,
   input  wire esd_pkg::esd_reg_req_s REG_REQ_I,
   output logic [7:0]                 REG_RDATA_O,
   output logic                       REG_RVALID_O,
   output logic                       CONV_A_ON_O,
   output logic                       CONV_B_ON_O,
   output logic                       LIN_REG_A_ON_O,
   output logic                       LIN_REG_B_ON_O,
   output logic                       GP_OUTPUT_O
);

   // ==========================================================
   // Delay and range registers
   logic [7:0] conv_a_sequence_delays;
   logic [7:0] conv_b_sequence_delays;
   logic [7:0] lin_reg_a_sequence_delays;
   logic [7:0] lin_reg_b_sequence_delays;
   logic [7:0] gp_output_sequence_delays;
   logic [7:0] config_range;

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         conv_a_sequence_delays    <= SEQ_RESET;
         conv_b_sequence_delays    <= SEQ_RESET;
         lin_reg_a_sequence_delays <= SEQ_RESET;
         lin_reg_b_sequence_delays <= SEQ_RESET;
         gp_output_sequence_delays <= SEQ_RESET;
         config_range              <= CONFIG_RESET;
      end else if (REG_REQ_I.wr) begin
         unique case (REG_REQ_I.addr)
            CONV_A_SEQ_ADDR:    conv_a_sequence_delays    <= REG_REQ_I.wdata;
            CONV_B_SEQ_ADDR:    conv_b_sequence_delays    <= REG_REQ_I.wdata;
            LIN_REG_A_SEQ_ADDR: lin_reg_a_sequence_delays <= REG_REQ_I.wdata;
            LIN_REG_B_SEQ_ADDR: lin_reg_b_sequence_delays <= REG_REQ_I.wdata;
            GP_OUTPUT_SEQ_ADDR: gp_output_sequence_delays <= REG_REQ_I.wdata;
            CONFIG_ADDR:        config_range <= REG_REQ_I.wdata & CONFIG_MASK;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Read-back, one cycle after the request
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         REG_RDATA_O  <= 8'h00;
         REG_RVALID_O <= 1'b0;
      end else begin
         REG_RVALID_O <= REG_REQ_I.rd;
         if (REG_REQ_I.rd) begin
            unique case (REG_REQ_I.addr)
               CONV_A_SEQ_ADDR:    REG_RDATA_O <= conv_a_sequence_delays;
               CONV_B_SEQ_ADDR:    REG_RDATA_O <= conv_b_sequence_delays;
               LIN_REG_A_SEQ_ADDR: REG_RDATA_O <= lin_reg_a_sequence_delays;
               LIN_REG_B_SEQ_ADDR: REG_RDATA_O <= lin_reg_b_sequence_delays;
               GP_OUTPUT_SEQ_ADDR: REG_RDATA_O <= gp_output_sequence_delays;
               CONFIG_ADDR:        REG_RDATA_O <= config_range;
               default:            REG_RDATA_O <= 8'h00;
            endcase
         end
      end
   end

   // ==========================================================
   // Enable pin synchroniser and edge pulses
   logic en_meta;
   logic en_sync;
   logic en_prev;
   logic en_rise;
   logic en_fall;

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         en_meta <= 1'b0;
         en_sync <= 1'b0;
         en_prev <= 1'b0;
         en_rise <= 1'b0;
         en_fall <= 1'b0;
      end else begin
         en_meta <= EN_PIN_I;
         en_sync <= en_meta;
         en_prev <= en_sync;
         en_rise <= en_sync & ~en_prev;
         en_fall <= ~en_sync & en_prev;
      end
   end

   // ==========================================================
   // Shared half-step time base, restarted on each enable edge
   logic [$clog2(HALF_STEP_CNT+1)-1:0] prescale;
   logic                               half_tick;

   assign half_tick = (prescale == ($bits(prescale))'(HALF_STEP_CNT - 1));

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         prescale <= '0;
      end else if (en_rise || en_fall || half_tick) begin
         prescale <= '0;
      end else begin
         prescale <= prescale + 1'b1;
      end
   end

   // ==========================================================
   // One timer per sequenced output
   logic [NUM_OUTPUTS-1:0][7:0] delay_regs;
   logic [NUM_OUTPUTS-1:0]      seq_out;

   assign delay_regs[0] = conv_a_sequence_delays;
   assign delay_regs[1] = conv_b_sequence_delays;
   assign delay_regs[2] = lin_reg_a_sequence_delays;
   assign delay_regs[3] = lin_reg_b_sequence_delays;
   assign delay_regs[4] = gp_output_sequence_delays;

   for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_timer
      esd_seq_timer u_timer (
         .clk_i       (CLK_I),
         .rst_i       (SYS_RST_I),
         .rise_i      (en_rise),
         .fall_i      (en_fall),
         .tick_i      (half_tick),
         .up_code_i   (delay_regs[g][UP_LSB +: CODE_W]),
         .down_code_i (delay_regs[g][DOWN_LSB +: CODE_W]),
         .up_long_i   (config_range[UP_RANGE_BIT]),
         .down_long_i (config_range[DOWN_RANGE_BIT]),
         .out_o       (seq_out[g])
      );
   end

   assign CONV_A_ON_O    = seq_out[0];
   assign CONV_B_ON_O    = seq_out[1];
   assign LIN_REG_A_ON_O = seq_out[2];
   assign LIN_REG_B_ON_O = seq_out[3];
   assign GP_OUTPUT_O    = seq_out[4];

endmodule : esd_sequencer
`default_nettype wire

// ---- testbench/esd_sequencer_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module esd_sequencer_chk
   import esd_pkg::*;
#(
   parameter int HALF_STEP_CNT = HALF_STEP_CYCLES
)(
   input wire logic                  CLK_I,
   input wire logic                  SYS_RST_I,
   input wire logic                  EN_PIN_I,
   input wire esd_pkg::esd_reg_req_s REG_REQ_I,
   input wire logic [7:0]            REG_RDATA_O,
   input wire logic                  REG_RVALID_O,
   input wire logic                  CONV_A_ON_O,
   input wire logic                  CONV_B_ON_O,
   input wire logic                  LIN_REG_A_ON_O,
   input wire logic                  LIN_REG_B_ON_O,
   input wire logic                  GP_OUTPUT_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SYS_RST_I);
   // ==========================================================
   // Outputs only rise toward a high enable pin; conv_a, lin_reg_b and gp_output only fall toward a low one
   AST_CA_UP: assert property ($rose(CONV_A_ON_O) |-> $past(EN_PIN_I, 3))
      else $error("conv_a rose while disabled");
   AST_CA_DN: assert property ($fell(CONV_A_ON_O) |-> !$past(EN_PIN_I, 3))
      else $error("conv_a fell while enabled");
   AST_CB_UP: assert property ($rose(CONV_B_ON_O) |-> EN_PIN_I && $past(EN_PIN_I, 3))
      else $error("conv_b rose while disabled");
   AST_LA_UP: assert property ($rose(LIN_REG_A_ON_O) |-> $past(EN_PIN_I, 3))
      else $error("lin_reg_a rose while disabled");
   AST_LB_UP: assert property ($rose(LIN_REG_B_ON_O) |-> $past(EN_PIN_I, 3))
      else $error("lin_reg_b rose while disabled");
   AST_LB_DN: assert property ($fell(LIN_REG_B_ON_O) |-> !EN_PIN_I && !$past(EN_PIN_I, 3))
      else $error("lin_reg_b fell while enabled");
   AST_GP_UP: assert property ($rose(GP_OUTPUT_O) |-> $past(EN_PIN_I, 3))
      else $error("gp_output rose while disabled");
   AST_GP_DN: assert property ($fell(GP_OUTPUT_O) |-> !$past(EN_PIN_I, 3))
      else $error("gp_output fell while enabled");
   COV_CA_UP: cover property ($rose(CONV_A_ON_O));
   COV_GP_DN: cover property ($fell(GP_OUTPUT_O));
   COV_READ: cover property (REG_RVALID_O);
endmodule : esd_sequencer_chk
bind esd_sequencer esd_sequencer_chk #(.HALF_STEP_CNT(HALF_STEP_CNT)) chk (
   .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .EN_PIN_I(EN_PIN_I), .REG_REQ_I(REG_REQ_I),
   .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O), .CONV_A_ON_O(CONV_A_ON_O),
   .CONV_B_ON_O(CONV_B_ON_O), .LIN_REG_A_ON_O(LIN_REG_A_ON_O),
   .LIN_REG_B_ON_O(LIN_REG_B_ON_O), .GP_OUTPUT_O(GP_OUTPUT_O));
`default_nettype wire

// ---- testbench/esd_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module esd_host
   import esd_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic [7:0]            rdata_i,
   input  wire logic                  rvalid_i,
   output var esd_pkg::esd_reg_req_s  req_o,
   output logic                       en_o
);
   initial begin
      req_o = '0;
      en_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      req_o.wr <= 1'b0;
   endtask : wr
   // Answer is valid in the cycle after the request edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk_i);
      req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      req_o.rd <= 1'b0;
      #1;
      v = rvalid_i;
      d = rdata_i;
   endtask : rd
   task automatic set_en(input logic lvl);
      @(posedge clk_i);
      en_o <= lvl;
   endtask : set_en
endmodule : esd_host
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
   import esd_pkg::*;
   localparam int N = 4;
   // Pin to output: two synchroniser flops, edge register, timer flop
   localparam int LAT = 4;
   logic         clk;
   logic         rst;
   logic         en;
   esd_reg_req_s req;
   logic [7:0]   rdata;
   logic         rvalid;
   logic [4:0]   outs;
   int           bad_count = 0;
   int           total_checks = 0;
   int           seed = 78864;
   int           up[5];
   int           dn[5];
   esd_host host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req), .en_o(en));
   esd_sequencer #(.HALF_STEP_CNT(N)) uut (.CLK_I(clk), .SYS_RST_I(rst), .EN_PIN_I(en),
      .REG_REQ_I(req), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .CONV_A_ON_O(outs[0]),
      .CONV_B_ON_O(outs[1]), .LIN_REG_A_ON_O(outs[2]), .LIN_REG_B_ON_O(outs[3]),
      .GP_OUTPUT_O(outs[4]));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       v;
      host.rd(a, d, v);
      check({7'h00, v}, 8'h01);
      check(d, e);
   endtask : rd_chk
   // ==========================================================
   // Time every output against code times step, all in one pass
   task automatic run_edge(input logic lvl, input logic rng);
      int         t[5];
      int         k;
      logic [4:0] hit;
      hit = '0;
      host.set_en(lvl);
      for (int c = 1; c <= 40 * N; c++) begin
         @(posedge clk);
         #1;
         for (int i = 0; i < 5; i++) if (!hit[i] && outs[i] === lvl) begin
            hit[i] = 1'b1;
            t[i] = c;
         end
      end
      for (int i = 0; i < 5; i++) begin
         k = (lvl ? up[i] : dn[i]) * (rng ? 2 : 1);
         check(8'(t[i]), 8'(k * N + LAT));
      end
   endtask : run_edge
   initial begin
      logic [7:0] val;
      rst = 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int a = 12; a <= 19; a++) rd_chk(8'(a), 8'h00);
      host.wr(8'h20, 8'hAA);
      rd_chk(8'h20, 8'h00);
      for (int r = 0; r < 4; r++) begin
         host.wr(CONFIG_ADDR, {1'b1, 2'(r), 5'h1F});
         rd_chk(CONFIG_ADDR, {1'b0, 2'(r), 5'h00});
         for (int i = 0; i < 5; i++) begin
            val = 8'($random(seed));
            if (r == 0) val = 8'h0F;
            up[i] = val[3:0];
            dn[i] = val[7:4];
            host.wr(CONV_A_SEQ_ADDR + 8'(i), val);
            rd_chk(CONV_A_SEQ_ADDR + 8'(i), val);
         end
         run_edge(1'b1, r[1]);
         run_edge(1'b0, r[0]);
      end
      // ==========================================================
      // Reset in mid-sequence with the pin high, then a cancelled fall
      host.set_en(1'b1);
      repeat (40) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check({3'h0, outs}, 8'h00);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (LAT) @(posedge clk);
      #1;
      check({3'h0, outs}, 8'h1F);
      for (int i = 0; i < 5; i++) host.wr(CONV_A_SEQ_ADDR + 8'(i), 8'hF0);
      host.set_en(1'b0);
      repeat (10) @(posedge clk);
      host.set_en(1'b1);
      val = 8'h1F;
      repeat (100) begin
         @(posedge clk);
         #1;
         val = val & {3'h0, outs};
      end
      check(val, 8'h1F);
      end_of_test();
   end
   initial begin
      #(40 * 5000);
      bad_count++;
      end_of_test();
   end
endmodule : tb
`default_nettype wire
